// *** include/dcs_map.vh ***
// Register offsets, field positions, reset values and encodings of the bank selector
`ifndef DCS_MAP_VH
`define DCS_MAP_VH

// Register byte offsets
`define DCS_CTRL_OFF      8'h00
`define DCS_FIT_OFF       8'h04
`define DCS_STATUS_OFF    8'h08
`define DCS_PMASK_OFF     8'h0c
`define DCS_LOW_OFF       8'h10
`define DCS_HIGH_OFF      8'h1c
`define DCS_THERM_OFF     8'h28

// Control register fields
`define DCS_CTRL_MULTIMOTOR  0
`define DCS_CTRL_TWO_LSB     1
`define DCS_CTRL_THREE_LSB   3
`define DCS_CTRL_AUTO_TUNE   5
`define DCS_CTRL_CMD0        6
`define DCS_CTRL_CMD1        7
`define DCS_CTRL_PSET_LSB    8
`define DCS_CTRL_RESET       10'h000

// Status register fields
`define DCS_ST_ACTIVE_LSB    0
`define DCS_ST_PEND_LSB      2
`define DCS_ST_FAULT         4
`define DCS_ST_STOPPED       5
`define DCS_ST_TUNED_LSB     6
`define DCS_ST_TUNING        9

// Selection source encodings
`define DCS_SRC_OFF          2'h0
`define DCS_SRC_INPUT        2'h1
`define DCS_SRC_CMD          2'h2

// Parameter mask bits that pick the switched speed limits
`define DCS_PM_LOW           0
`define DCS_PM_HIGH          1
`define DCS_PMASK_RESET      15'h0000

// Reset values
`define DCS_FIT_RESET        24'h000000
`define DCS_LOW_RESET        16'h0000
`define DCS_HIGH_RESET       16'hffff
`define DCS_THERM_RESET      16'h0000

`endif

// *** hw/dcs_sync.v ***
// Three-stage pin synchroniser that accepts a level once the last two stages agree
`timescale 1ns/1ps
module dcs_sync (
  input  wire clk,
  input  wire sys_rst,
  input  wire pin,
  output reg  level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // Shift the pin through three flops; only stages two and three are compared
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level <= stage3;
    end
  end

endmodule

// *** hw/dcs_thermal.v ***
// Per-motor thermal state: heats while its motor runs, cools at rest, reloadable
`timescale 1ns/1ps
module dcs_thermal #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         heat,
  input  wire [7:0]   load,
  input  wire         load_state,
  input  wire [W-1:0] new_state,
  output reg  [W-1:0] state
);

  wire [W:0] sum;

  assign sum = {1'b0, state} + {{(W-7){1'b0}}, load};

  // Saturating heat or cool step; a software load restores the state after power-off
  always @(posedge clk)
  begin
    if (sys_rst)
      state <= {W{1'b0}};
    else if (load_state)
      state <= new_state;
    else if (heat)
      state <= sum[W] ? {W{1'b1}} : sum[W-1:0];
    else if (state != {W{1'b0}})
      state <= state - {{(W-1){1'b0}}, 1'b1};
  end

endmodule

// *** hw/dcs_selector.v ***
// Drive configuration bank selector with APB registers, auto-tune and thermal tracking
`timescale 1ns/1ps
`include "dcs_map.vh"

// Requirements this block is written to
// [RQ1] Holds three stored configurations, remotely selectable
// [RQ2] Runs multimotor or multiconfiguration, never both
// [RQ3] Changes bank only when stopped and locked
// [RQ4] Request while running waits for next stop
// [RQ5] Decode: 00 bank0, 10 bank1, x1 bank2
// [RQ6] Fit-out mismatch locks drive and flags fault
// [RQ7] Multimotor switches every group per bank
// [RQ8] Multiconfiguration keeps motor data common to banks
// [RQ9] Auto-tunes each motor on first run after power-on
// [RQ10] Discrete input starts tune after motor change
// [RQ11] Separate thermal state kept for each motor
// [RQ12] Thermal state reloadable to cover power-off time
// [RQ13] One status output per bank, asserted while active
// [RQ14] User assigns status outputs in every bank; here each bank drives its own fixed bank_out bit
// [RQ15] External gear switches motor terminals with bank
// [RQ16] One to fifteen parameters chosen, toggled individually; here only mask bits DCS_PM_LOW and DCS_PM_HIGH switch a speed limit
// [RQ17] Low speed clamped below lowest high speed
// [RQ18] User tests set switching while stopped
// [RQ19] Two-bank source: off, discrete input, command bit
// [RQ20] Three-bank source needs two-bank source configured
// [RQ21] Pending selection copied to active on stop
module dcs_selector #(
  parameter NB = 3,
  parameter TW = 16
) (
  input  wire          clk,
  input  wire          sys_rst,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          sel_in0,
  input  wire          sel_in1,
  input  wire          tune_in,
  input  wire          drive_running,
  input  wire          power_locked,
  input  wire [7:0]    hw_fitout,
  input  wire [7:0]    motor_load,
  input  wire          tune_done,
  output reg  [1:0]    active_bank,
  output reg  [1:0]    motor_bank,
  output reg  [NB-1:0] bank_out,
  output reg           bank_hardware_mismatch_fault,
  output reg           drive_lock,
  output reg           tune_start,
  output reg  [15:0]   low_speed_limit,
  output reg  [15:0]   high_speed_limit
);

  // Bank number from the two selection levels
  function [1:0] dcs_decode;
    input s0;
    input s1;
    begin
      dcs_decode = s1 ? 2'h2 : (s0 ? 2'h1 : 2'h0);
    end
  endfunction

  reg  [9:0]    ctrl;
  reg  [23:0]   fit;
  reg  [14:0]   pmask;
  reg  [15:0]   low_set  [0:NB-1];
  reg  [15:0]   high_set [0:NB-1];
  reg  [1:0]    pending;
  reg  [NB-1:0] tuned;
  reg           tuning;
  reg           changed;
  reg           tune_prev;
  reg  [1:0]    tune_bank;
  wire          di0;
  wire          di1;
  wire          di_tune;
  wire          wr;
  wire          rd;
  wire          stopped;
  wire          sel0;
  wire          sel1;
  wire [1:0]    two_src;
  wire [1:0]    three_src;
  wire [1:0]    next_pending;
  wire [1:0]    pset;
  wire [7:0]    stored_fit;
  wire [TW-1:0] therm [0:NB-1];
  wire [15:0]   min_high;
  wire [15:0]   pick_low;
  wire [15:0]   pick_high;
  wire          run_start;
  reg           run_prev;
  reg  [31:0]   next_prdata;
  reg           next_err;

  // Pin inputs pass the three-stage synchroniser
  dcs_sync u_sync0 (.clk(clk), .sys_rst(sys_rst), .pin(sel_in0), .level(di0));
  dcs_sync u_sync1 (.clk(clk), .sys_rst(sys_rst), .pin(sel_in1), .level(di1));
  dcs_sync u_synct (.clk(clk), .sys_rst(sys_rst), .pin(tune_in), .level(di_tune));

  assign wr        = psel & penable & pwrite;
  assign rd        = psel & penable & ~pwrite;
  assign stopped   = ~drive_running & power_locked;
  assign two_src   = ctrl[`DCS_CTRL_TWO_LSB+1:`DCS_CTRL_TWO_LSB];
  assign three_src = ctrl[`DCS_CTRL_THREE_LSB+1:`DCS_CTRL_THREE_LSB];
  assign pset      = ctrl[`DCS_CTRL_PSET_LSB+1:`DCS_CTRL_PSET_LSB];

  // Selection sources: off, discrete input or command bit
  assign sel0 = (two_src == `DCS_SRC_INPUT) ? di0 :
                (two_src == `DCS_SRC_CMD) ? ctrl[`DCS_CTRL_CMD0] : 1'b0; // see [RQ19]
  assign sel1 = (two_src == `DCS_SRC_OFF) ? 1'b0 :
                (three_src == `DCS_SRC_INPUT) ? di1 :
                (three_src == `DCS_SRC_CMD) ? ctrl[`DCS_CTRL_CMD1] : 1'b0; // see [RQ20]
  assign next_pending = dcs_decode(sel0, sel1); // see [RQ5]

  // Fit-out saved with the pending bank
  assign stored_fit = (pending == 2'h2) ? fit[23:16] :
                      (pending == 2'h1) ? fit[15:8] : fit[7:0];

  // Pending selection, applied on the first stopped cycle
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pending     <= 2'h0;
      active_bank <= 2'h0;
      motor_bank  <= 2'h0;
      bank_out    <= {{(NB-1){1'b0}}, 1'b1};
    end
    else
    begin
      pending <= next_pending; // see [RQ4]
      if (stopped)
      begin
        active_bank <= pending; // see [RQ3] [RQ21] [RQ1]
        bank_out    <= {{(NB-1){1'b0}}, 1'b1} << pending; // see [RQ13]
        // Motor data follow the bank only in multimotor mode
        motor_bank  <= ctrl[`DCS_CTRL_MULTIMOTOR] ? pending : 2'h0; // see [RQ2] [RQ7] [RQ8]
      end
    end
  end

  // Fit-out mismatch fault; a new mismatch wins over a clear write
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      bank_hardware_mismatch_fault <= 1'b0;
      drive_lock                   <= 1'b0;
    end
    else if (stopped && stored_fit != hw_fitout)
    begin
      bank_hardware_mismatch_fault <= 1'b1; // see [RQ6]
      drive_lock                   <= 1'b1;
    end
    else if (wr && paddr == `DCS_STATUS_OFF && pwdata[`DCS_ST_FAULT])
    begin
      bank_hardware_mismatch_fault <= 1'b0;
      drive_lock                   <= 1'b0;
    end
  end

  // Auto-tune on first run per motor, or by input after a bank change
  assign run_start = drive_running & ~run_prev;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      tuned      <= {NB{1'b0}};
      tuning     <= 1'b0;
      tune_start <= 1'b0;
      changed    <= 1'b0;
      tune_prev  <= 1'b0;
      run_prev   <= 1'b0;
      tune_bank  <= 2'h0;
    end
    else
    begin
      run_prev   <= drive_running;
      tune_prev  <= di_tune;
      tune_start <= 1'b0;
      if (stopped && pending != active_bank)
        changed <= 1'b1;
      if (tuning)
      begin
        if (tune_done)
        begin
          tuning           <= 1'b0;
          tuned[tune_bank] <= 1'b1;
        end
      end
      else if (run_start && ctrl[`DCS_CTRL_AUTO_TUNE] && !tuned[motor_bank])
      begin
        tuning     <= 1'b1; // see [RQ9]
        tune_start <= 1'b1;
        tune_bank  <= motor_bank;
      end
      else if (di_tune && !tune_prev && changed && stopped)
      begin
        tuning     <= 1'b1; // see [RQ10]
        tune_start <= 1'b1;
        tune_bank  <= motor_bank;
        changed    <= (pending != active_bank); // A bank change in this cycle wins over the clear
      end
    end
  end

  // One thermal model per motor, each heated only while its motor runs
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1)
    begin : g_therm
      dcs_thermal #(.W(TW)) u_therm (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .heat       (drive_running && motor_bank == g),
        .load       (motor_load),
        .load_state (wr && paddr == `DCS_THERM_OFF + 8'h04 * g),
        .new_state  (pwdata[TW-1:0]),
        .state      (therm[g])
      ); // see [RQ11] [RQ12]
    end
  endgenerate

  // Speed limits of the selected parameter set, or set 0 when not chosen
  assign pick_low  = pmask[`DCS_PM_LOW]  ? low_set[pset]  : low_set[0];
  assign pick_high = pmask[`DCS_PM_HIGH] ? high_set[pset] : high_set[0];
  assign min_high  = (high_set[0] < high_set[1]) ?
                     ((high_set[0] < high_set[2]) ? high_set[0] : high_set[2]) :
                     ((high_set[1] < high_set[2]) ? high_set[1] : high_set[2]);

  // Clamp the low limit below the lowest high limit of all sets
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      low_speed_limit  <= `DCS_LOW_RESET;
      high_speed_limit <= `DCS_HIGH_RESET;
    end
    else
    begin
      high_speed_limit <= pick_high;
      if (pick_low >= min_high)
        low_speed_limit <= (min_high == 16'h0000) ? 16'h0000 : min_high - 16'h0001; // see [RQ17]
      else
        low_speed_limit <= pick_low;
    end
  end

  // Register writes
  integer i;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl  <= `DCS_CTRL_RESET;
      fit   <= `DCS_FIT_RESET;
      pmask <= `DCS_PMASK_RESET;
      for (i = 0; i < NB; i = i + 1)
      begin
        low_set[i]  <= `DCS_LOW_RESET;
        high_set[i] <= `DCS_HIGH_RESET;
      end
    end
    else if (wr)
    begin
      if (paddr == `DCS_CTRL_OFF)
        ctrl <= pwdata[9:0];
      if (paddr == `DCS_FIT_OFF)
        fit <= pwdata[23:0];
      if (paddr == `DCS_PMASK_OFF)
        pmask <= pmask ^ pwdata[14:0]; // see [RQ16]
      for (i = 0; i < NB; i = i + 1)
      begin
        if (paddr == `DCS_LOW_OFF + 8'h04 * i[7:0])
          low_set[i] <= pwdata[15:0];
        if (paddr == `DCS_HIGH_OFF + 8'h04 * i[7:0])
          high_set[i] <= pwdata[15:0];
      end
    end
  end

  // Read mux and unmapped-address error
  always @*
  begin
    next_prdata = 32'h00000000;
    next_err    = 1'b0;
    case (paddr)
      `DCS_CTRL_OFF:   next_prdata = {22'h000000, ctrl};
      `DCS_FIT_OFF:    next_prdata = {8'h00, fit};
      `DCS_STATUS_OFF: next_prdata = {22'h000000, tuning, tuned, stopped,
                                      bank_hardware_mismatch_fault, pending, active_bank};
      `DCS_PMASK_OFF:  next_prdata = {17'h00000, pmask};
      8'h10:           next_prdata = {16'h0000, low_set[0]};
      8'h14:           next_prdata = {16'h0000, low_set[1]};
      8'h18:           next_prdata = {16'h0000, low_set[2]};
      8'h1c:           next_prdata = {16'h0000, high_set[0]};
      8'h20:           next_prdata = {16'h0000, high_set[1]};
      8'h24:           next_prdata = {16'h0000, high_set[2]};
      8'h28:           next_prdata = {{(32-TW){1'b0}}, therm[0]};
      8'h2c:           next_prdata = {{(32-TW){1'b0}}, therm[1]};
      8'h30:           next_prdata = {{(32-TW){1'b0}}, therm[2]};
      default:         next_err    = 1'b1;
    endcase
  end

  // APB answer: ready in the first access cycle, data and error registered
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      if (psel && !penable && !pwrite)
        prdata <= next_prdata;
      else if (!rd)
        prdata <= 32'h00000000;
    end
  end

endmodule

// *** dv/dcs_selector_sva.sv ***
// Port-level assertions for the bank selector
`timescale 1ns/1ps
`include "dcs_map.vh"
module dcs_selector_sva #(
  parameter NB = 3
) (
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic          pready,
  input wire logic          drive_running,
  input wire logic          power_locked,
  input wire logic [1:0]    active_bank,
  input wire logic [1:0]    motor_bank,
  input wire logic [NB-1:0] bank_out,
  input wire logic          bank_hardware_mismatch_fault,
  input wire logic          drive_lock,
  input wire logic          tune_start,
  input wire logic [15:0]   low_speed_limit,
  input wire logic [15:0]   high_speed_limit
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire stopped = !drive_running && power_locked;
  wire clr_wr  = psel && penable && pwrite && paddr == `DCS_STATUS_OFF;
  // Bus answer takes exactly one access cycle
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer_once: assert property (apb_setup |=> apb_answer)
    else $error("pready not a single pulse after setup");
  a_bank_when_stopped: assert property (active_bank != $past(active_bank) |-> $past(stopped))
    else $error("active bank changed while not stopped");
  a_hold_while_run: assert property (drive_running |=> $stable(active_bank))
    else $error("active bank changed while running");
  a_bank_in_range: assert property (active_bank != 2'h3)
    else $error("active bank out of range");
  a_status_onehot: assert property (bank_out == ({{(NB-1){1'b0}}, 1'b1} << active_bank))
    else $error("status outputs do not show active bank");
  a_single_mode: assert property (motor_bank == active_bank || motor_bank == 2'h0)
    else $error("motor bank neither active nor common");
  a_lock_with_fault: assert property (drive_lock == bank_hardware_mismatch_fault)
    else $error("lock differs from mismatch fault");
  a_fault_sticky: assert property (bank_hardware_mismatch_fault && !clr_wr |=> bank_hardware_mismatch_fault)
    else $error("mismatch fault dropped without clear");
  a_tune_pulse: assert property (tune_start |=> !tune_start)
    else $error("tune start longer than one cycle");
  a_low_below_high: assert property (high_speed_limit != 16'h0000 |-> low_speed_limit < high_speed_limit)
    else $error("low limit not below high limit");
endmodule

// *** dv/dcs_ctl_model.sv ***
// Machine controller model: selection pins, run, lock and tune request
`timescale 1ns/1ps
module dcs_ctl_model (
  input  wire  clk,
  output logic sel_in0,
  output logic sel_in1,
  output logic drive_running,
  output logic power_locked,
  output logic tune_in
);
  // Powered up stopped and locked
  initial
  begin
    {sel_in0, sel_in1, drive_running, tune_in} = 0;
    power_locked = 1;
  end
  // Contactors follow the selection pins
  task pins(input logic a, input logic b);
    @(posedge clk);
    sel_in0 <= a;
    sel_in1 <= b;
  endtask
  // Run and lock state of the power stage
  task state(input logic r, input logic l);
    @(posedge clk);
    drive_running <= r;
    power_locked  <= l;
  endtask
  // Tune request held long enough for the pin filter to accept it
  task tune;
    @(posedge clk);
    tune_in <= 1;
    repeat (4) @(posedge clk);
    tune_in <= 0;
  endtask
endmodule

// *** dv/drive_config_set_selector_test.sv ***
// Self-checking bench for the bank selector
`timescale 1ns/1ps
module drive_config_set_selector_test;
  logic        clk, sys_rst, psel, penable, pwrite, tune_done, pready, pslverr, er;
  logic        sel_in0, sel_in1, tune_in, drive_running, power_locked;
  logic        bank_hardware_mismatch_fault, drive_lock, tune_start;
  logic [7:0]  paddr, hw_fitout, motor_load;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  active_bank, motor_bank;
  logic [2:0]  bank_out;
  logic [15:0] low_speed_limit, high_speed_limit;
  int          errors, total_checks, tunes, r;
  int          q[$];
  dcs_selector #(.NB(3)) dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sel_in0, .sel_in1, .tune_in, .drive_running, .power_locked,
    .hw_fitout, .motor_load, .tune_done, .active_bank, .motor_bank, .bank_out,
    .bank_hardware_mismatch_fault, .drive_lock, .tune_start, .low_speed_limit, .high_speed_limit);
  dcs_ctl_model ctl (.clk, .sel_in0, .sel_in1, .drive_running, .power_locked, .tune_in);
  // Clock and tune pulse counter
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (tune_start === 1'b1) tunes++;
  task end_of_test;
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Reference decode of the selection
  function automatic int dec(input int a, input int b, input int two, input int three);
    if (two == 0) return 0;
    if (b != 0 && three != 0) return 2;
    return a;
  endfunction
  task wbank(input int e);
    int n;
    n = 0;
    while (active_bank !== e[1:0] && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(active_bank, e);
    chk(bank_out, 1 << e);
  endtask
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, tune_done, paddr, pwdata, hw_fitout, motor_load} = 0;
    sys_rst = 1;
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    void'($urandom(38));
    motor_load <= 8'($urandom);
    repeat (4) @(posedge clk);
    chk(bank_out, 3'h1);
    apb(0, 8'h08, 0);
    chk(rd, 32'h20);
    apb(1, 8'h00, 32'h0b);
    for (int i = 0; i < 4; i++)
    begin
      ctl.pins(i[0], i[1]);
      wbank(dec(i % 2, i / 2, 1, 1));
      chk(motor_bank, dec(i % 2, i / 2, 1, 1));
    end
    ctl.state(1, 0);
    ctl.pins(1, 0);
    repeat (10) @(posedge clk);
    chk(active_bank, 2);
    ctl.state(0, 0);
    repeat (10) @(posedge clk);
    chk(active_bank, 2);
    ctl.state(0, 1);
    wbank(1);
    apb(1, 8'h00, 32'h0a);
    repeat (2) @(posedge clk);
    chk(motor_bank, 0);
    apb(1, 8'h00, 32'h08);
    ctl.pins(1, 1);
    repeat (6) @(posedge clk);
    wbank(dec(1, 1, 0, 1));
    apb(1, 8'h00, 32'h44);
    wbank(dec(1, 0, 2, 0));
    apb(1, 8'h00, 32'hd4);
    wbank(dec(1, 1, 2, 2));
    apb(1, 8'h00, 32'h0a);
    repeat (8) q.push_back($urandom % 4);
    foreach (q[i])
    begin
      ctl.pins(q[i][0], q[i][1]);
      wbank(dec(q[i] % 2, q[i] / 2, 1, 1));
    end
    apb(0, 8'h40, 0);
    chk(er, 1);
    chk(rd, 0);
    ctl.pins(1, 1);
    wbank(2);
    apb(1, 8'h04, 32'h330000);
    repeat (4) @(posedge clk);
    chk(drive_lock, 1);
    apb(1, 8'h08, 32'h10);
    repeat (2) @(posedge clk);
    chk(bank_hardware_mismatch_fault, 1);
    apb(1, 8'h04, 0);
    apb(1, 8'h08, 32'h10);
    repeat (2) @(posedge clk);
    chk(bank_hardware_mismatch_fault, 0);
    apb(1, 8'h00, 32'h2b);
    ctl.state(1, 0);
    repeat (4) @(posedge clk);
    chk(tunes, 1);
    tune_done <= 1;
    @(posedge clk);
    tune_done <= 0;
    ctl.state(0, 1);
    ctl.state(1, 0);
    repeat (4) @(posedge clk);
    chk(tunes, 1);
    ctl.state(0, 1);
    ctl.pins(0, 0);
    wbank(0);
    ctl.tune;
    repeat (6) @(posedge clk);
    chk(tunes, 2);
    apb(1, 8'h10, 32'h500);
    apb(1, 8'h1c, 32'h400);
    apb(1, 8'h0c, 32'h3);
    repeat (2) @(posedge clk);
    chk(low_speed_limit, 16'h3ff);
    chk(high_speed_limit, 16'h400);
    // Set 1 chosen: the switched high limit follows it until its mask bit is toggled off
    apb(1, 8'h20, 32'h600);
    apb(1, 8'h00, 32'h12b);
    repeat (2) @(posedge clk);
    chk(high_speed_limit, 16'h600);
    apb(1, 8'h0c, 32'h2);
    repeat (2) @(posedge clk);
    chk(high_speed_limit, 16'h400);
    // Reloaded thermal state cools one step before it is read; motor 0 stays cold
    r = 32'h8000 | ($urandom % 32'h1000);
    apb(1, 8'h2c, r);
    apb(0, 8'h2c, 0);
    chk(rd, r - 1);
    apb(0, 8'h28, 0);
    chk(rd, 0);
    end_of_test;
  end
  // Watchdog
  initial
  begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule
bind dcs_selector dcs_selector_sva #(.NB(NB)) sva (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .drive_running(drive_running),
  .power_locked(power_locked), .active_bank(active_bank), .motor_bank(motor_bank), .bank_out(bank_out),
  .bank_hardware_mismatch_fault(bank_hardware_mismatch_fault), .drive_lock(drive_lock),
  .tune_start(tune_start), .low_speed_limit(low_speed_limit), .high_speed_limit(high_speed_limit));
